// ### verilog/sdpc_params.svh
// Timing counts, command encodings and mode defaults of the SDRAM init and self-refresh controller.
// Assumes a 40 MHz sys_clk; counts other than SDPC_TMRS_CYC and SDPC_CLK_STABLE_CYC are derived from times in nanoseconds.
`ifndef SDPC_PARAMS_SVH
`define SDPC_PARAMS_SVH
`define SDPC_CLK_PERIOD_NS      25
`define SDPC_PAUSE_NS           200000
`define SDPC_PAUSE_CYC          ((`SDPC_PAUSE_NS + `SDPC_CLK_PERIOD_NS - 1) / `SDPC_CLK_PERIOD_NS)
`define SDPC_TRP_NS             20
`define SDPC_TRP_CYC            ((`SDPC_TRP_NS + `SDPC_CLK_PERIOD_NS - 1) / `SDPC_CLK_PERIOD_NS)
`define SDPC_TRC_NS             70
`define SDPC_TRC_CYC            ((`SDPC_TRC_NS + `SDPC_CLK_PERIOD_NS - 1) / `SDPC_CLK_PERIOD_NS)
`define SDPC_TRAS_NS            45
`define SDPC_TRAS_CYC           ((`SDPC_TRAS_NS + `SDPC_CLK_PERIOD_NS - 1) / `SDPC_CLK_PERIOD_NS)
`define SDPC_SELF_REFRESH_EXIT_HOLD_NS            10
`define SDPC_SELF_REFRESH_EXIT_HOLD_CYC           ((`SDPC_SELF_REFRESH_EXIT_HOLD_NS + `SDPC_CLK_PERIOD_NS - 1) / `SDPC_CLK_PERIOD_NS)
`define SDPC_TMRS_CYC           2
`define SDPC_CLK_STABLE_CYC     4
`define SDPC_INIT_REFRESHES     2
`define SDPC_BURST_REFRESHES    2048
`define SDPC_MODE_DEFAULT       13'h0022
// Command encodings as {chip select, row strobe, column strobe, write strobe}, all active low.
`define SDPC_CMD_NOP            4'h7
`define SDPC_CMD_PRECHARGE      4'h2
`define SDPC_CMD_MODE_SET       4'h0
`define SDPC_CMD_REFRESH        4'h1
`define SDPC_CMD_DESELECT       4'hf
`define SDPC_A10_BIT            10
`endif

// ### verilog/sdpc_pkg.sv
// Types shared by the SDRAM init and self-refresh controller.
// Assumes sdpc_params.svh for numeric constants.
package sdpc_pkg;
    typedef struct packed {
        logic        chipSelectN;
        logic        rowStrobeN;
        logic        columnStrobeN;
        logic        writeStrobeN;
    } sdpc_cmd_s;

    typedef struct packed {
        sdpc_cmd_s   cmd;
        logic        clockGate;
        logic [3:0]  byteMask;
        logic [1:0]  bank;
        logic [12:0] addr;
    } sdpc_pins_s;

    typedef enum logic [11:0] {
        ST_PAUSE      = 12'h001,
        ST_PRECHARGE  = 12'h002,
        ST_WAIT_RP    = 12'h004,
        ST_MODE_SET   = 12'h008,
        ST_WAIT_MRS   = 12'h010,
        ST_REFRESH    = 12'h020,
        ST_WAIT_RC    = 12'h040,
        ST_READY      = 12'h080,
        ST_SR_ENTER   = 12'h100,
        ST_SR_HOLD    = 12'h200,
        ST_SR_CLKUP   = 12'h400,
        ST_SR_EXIT    = 12'h800
    } sdpc_state_e;
endpackage

// ### verilog/sdpc_ctrl.sv
// Controller that powers up an SDRAM and moves it into and out of self refresh.
// Assumes the memory samples pins on the rising sys_clk and sysClkRun gates the memory clock outside.
`timescale 1ns/1ps
`include "sdpc_params.svh"
module sdpc_ctrl #(
    parameter int unsigned PAUSE_CYC   = `SDPC_PAUSE_CYC,
    parameter int unsigned BURST_COUNT = `SDPC_BURST_REFRESHES,
    parameter logic [12:0] MODE_VALUE  = `SDPC_MODE_DEFAULT
) (
    input  wire logic               sys_clk,
    input  wire logic               reset,
    input  wire logic               clkEn,
    input  wire logic               burstRefreshMode,
    input  wire logic               selfRefreshReq,
    input  wire logic               suspendReq,
    output sdpc_pkg::sdpc_pins_s    memPins,
    output logic                    sysClkRun,
    output logic                    initDone,
    output logic                    inSelfRefresh,
    output logic                    suspended
);
    import sdpc_pkg::*;

    localparam int CW = 16;

    sdpc_state_e state;
    sdpc_state_e next_state;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic [11:0]   refreshLeft;
    logic [11:0]   next_refreshLeft;
    logic          afterSelfRefresh;
    logic          next_afterSelfRefresh;
    sdpc_pins_s    next_memPins;
    logic          next_sysClkRun;
    logic          next_initDone;
    logic          next_inSelfRefresh;
    logic          next_suspended;

    function automatic sdpc_pins_s pinsFor(input logic [3:0] cmd, input logic gate, input logic [3:0] mask);
        sdpc_pins_s p;
        p.cmd      = sdpc_cmd_s'(cmd);
        p.clockGate = gate;
        p.byteMask = mask;
        p.bank     = 2'h0;
        p.addr     = 13'h0000;
        return p;
    endfunction

    // Counters load n-1 because the state that loads them already spends one cycle.
    function automatic logic [CW-1:0] cyc(input int unsigned n);
        return CW'(n > 0 ? n - 1 : 0);
    endfunction

    // Defaults give a NOP with the gate high, so a state that sets no pin is still harmless on the bus.
    always_comb begin
        next_state            = state;
        next_count            = (count != '0) ? count - CW'(1) : count;
        next_refreshLeft      = refreshLeft;
        next_afterSelfRefresh = afterSelfRefresh;
        next_memPins          = pinsFor(`SDPC_CMD_NOP, 1'b1, 4'hf);
        next_sysClkRun        = 1'b1;
        next_initDone         = initDone;
        next_inSelfRefresh    = 1'b0;
        next_suspended        = 1'b0;
        case (state)
            ST_PAUSE: begin
                if (count == '0) begin
                    next_state   = ST_PRECHARGE;
                end
            end
            ST_PRECHARGE: begin
                next_memPins = pinsFor(`SDPC_CMD_PRECHARGE, 1'b1, 4'hf);
                next_memPins.addr[`SDPC_A10_BIT] = 1'b1;
                next_count = cyc(`SDPC_TRP_CYC);
                next_state = ST_WAIT_RP;
            end
            ST_WAIT_RP: begin
                if (count == '0) begin
                    next_state = ST_MODE_SET;
                end
            end
            ST_MODE_SET: begin
                next_memPins      = pinsFor(`SDPC_CMD_MODE_SET, 1'b1, 4'hf);
                next_memPins.addr = MODE_VALUE;
                next_count        = cyc(`SDPC_TMRS_CYC);
                next_refreshLeft  = 12'(`SDPC_INIT_REFRESHES);
                next_state        = ST_WAIT_MRS;
            end
            ST_WAIT_MRS: begin
                if (count == '0) begin
                    next_state = ST_REFRESH;
                end
            end
            ST_REFRESH: begin
                // One loop serves init and both burst phases; refreshLeft holds how many are still owed.
                next_memPins     = pinsFor(`SDPC_CMD_REFRESH, 1'b1, 4'hf);
                next_refreshLeft = refreshLeft - 12'h001;
                next_count       = cyc(`SDPC_TRC_CYC);
                next_state       = ST_WAIT_RC;
            end
            ST_WAIT_RC: begin
                if (count == '0) begin
                    if (refreshLeft != '0) begin
                        next_state = ST_REFRESH;
                    end else if (!initDone || afterSelfRefresh) begin
                        next_initDone         = 1'b1;
                        next_afterSelfRefresh = 1'b0;
                        next_state            = ST_READY;
                    end else begin
                        next_state = ST_SR_ENTER;
                    end
                end
            end
            ST_READY: begin
                next_memPins.byteMask = 4'h0;
                // The memory freezes and thaws one clock after the gate moves, so the flag trails the gate.
                // A single-cycle suspend still raises the flag for the cycle the memory really stood still.
                next_suspended = !memPins.clockGate;
                if (suspendReq) begin
                    next_memPins.clockGate = 1'b0;
                end else if (selfRefreshReq) begin
                    if (burstRefreshMode) begin
                        next_refreshLeft = 12'(BURST_COUNT);
                        next_state       = ST_REFRESH;
                    end else begin
                        next_state = ST_SR_ENTER;
                    end
                end
            end
            ST_SR_ENTER: begin
                next_memPins       = pinsFor(`SDPC_CMD_REFRESH, 1'b0, 4'hf);
                next_inSelfRefresh = 1'b1;
                next_count         = cyc(`SDPC_TRAS_CYC);
                next_state         = ST_SR_HOLD;
            end
            ST_SR_HOLD: begin
                // The clock may only stop here, after the memory has taken the entry command.
                next_memPins       = pinsFor(`SDPC_CMD_DESELECT, 1'b0, 4'hf);
                next_inSelfRefresh = 1'b1;
                next_sysClkRun     = 1'b0;
                if (count == '0 && !selfRefreshReq) begin
                    next_sysClkRun = 1'b1;
                    next_count     = cyc(`SDPC_CLK_STABLE_CYC);
                    next_state     = ST_SR_CLKUP;
                end
            end
            ST_SR_CLKUP: begin
                next_memPins       = pinsFor(`SDPC_CMD_DESELECT, 1'b0, 4'hf);
                next_inSelfRefresh = 1'b1;
                if (count == '0) begin
                    next_memPins.clockGate = 1'b1;
                    next_count = cyc(`SDPC_TRC_CYC > `SDPC_SELF_REFRESH_EXIT_HOLD_CYC ? `SDPC_TRC_CYC : `SDPC_SELF_REFRESH_EXIT_HOLD_CYC);
                    next_state = ST_SR_EXIT;
                end
            end
            ST_SR_EXIT: begin
                // Deselect covers both the exit hold and the row cycle, so one wait serves both limits.
                next_memPins       = pinsFor(`SDPC_CMD_DESELECT, 1'b1, 4'hf);
                next_inSelfRefresh = 1'b1;
                if (count == '0) begin
                    next_inSelfRefresh = 1'b0;
                    if (burstRefreshMode) begin
                        next_refreshLeft      = 12'(BURST_COUNT);
                        next_afterSelfRefresh = 1'b1;
                        next_state            = ST_REFRESH;
                    end else begin
                        next_state = ST_READY;
                    end
                end
            end
            default: begin
                next_state = ST_PAUSE;
            end
        endcase
    end

    // Reset drives the power-up pin state at once, so the memory never sees a stray command meanwhile.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state            <= ST_PAUSE;
            count            <= cyc(PAUSE_CYC);
            refreshLeft      <= 12'h000;
            afterSelfRefresh <= 1'b0;
            memPins          <= {4'h7, 1'b1, 4'hf, 2'h0, 13'h0000};
            sysClkRun        <= 1'b1;
            initDone         <= 1'b0;
            inSelfRefresh    <= 1'b0;
            suspended        <= 1'b0;
        end else if (clkEn) begin
            state            <= next_state;
            count            <= next_count;
            refreshLeft      <= next_refreshLeft;
            afterSelfRefresh <= next_afterSelfRefresh;
            memPins          <= next_memPins;
            sysClkRun        <= next_sysClkRun;
            initDone         <= next_initDone;
            inSelfRefresh    <= next_inSelfRefresh;
            suspended        <= next_suspended;
        end
    end
endmodule // sdpc_ctrl

// ### tb/sdpc_ctrl_properties.sv
// Assertions on the pins of the SDRAM init and self-refresh controller.
// Assumes a bind to sdpc_ctrl; the pause count follows the design's own PAUSE_CYC, other counts are fixed literals.
`timescale 1ns/1ps
`include "sdpc_params.svh"
module sdpc_ctrl_chk #(
    parameter int unsigned PAUSE_CYC  = 20,
    parameter logic [12:0] MODE_VALUE = 13'h0000
) (
    input wire logic                 sys_clk,
    input wire logic                 reset,
    input wire logic                 clkEn,
    input wire sdpc_pkg::sdpc_pins_s memPins,
    input wire logic                 sysClkRun,
    input wire logic                 initDone,
    input wire logic                 inSelfRefresh,
    input wire logic                 suspended
);
    import sdpc_pkg::*;
    logic [15:0] pauseCnt;
    logic        seenCmd;
    logic [1:0]  refCnt;
    logic [3:0]  cmd;
    logic        busy;
    logic        entry;
    assign cmd = memPins.cmd;
    assign busy = cmd != `SDPC_CMD_NOP && cmd != `SDPC_CMD_DESELECT;
    assign entry = cmd == `SDPC_CMD_REFRESH && !memPins.clockGate;
    // Saturating counters, so a long run never wraps back into the pause window.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pauseCnt <= '0;
            seenCmd <= 1'b0;
            refCnt <= '0;
        end else begin
            if (clkEn && pauseCnt != 16'hffff)
                pauseCnt <= pauseCnt + 16'h1;
            seenCmd <= seenCmd | busy;
            if (cmd == `SDPC_CMD_REFRESH && !initDone && refCnt != 2'h3)
                refCnt <= refCnt + 2'h1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_pre;
        cmd == `SDPC_CMD_PRECHARGE && !initDone;
    endsequence
    sequence s_exit;
        $rose(memPins.clockGate) && inSelfRefresh;
    endsequence
    a_pause_quiet: assert property (
        pauseCnt < PAUSE_CYC |-> cmd == `SDPC_CMD_NOP && memPins.clockGate && memPins.byteMask == 4'hf)
        else $error("pins not quiet during pause");
    a_first_precharge: assert property (
        !seenCmd && busy |-> cmd == `SDPC_CMD_PRECHARGE && memPins.addr[10]) else $error("first command wrong");
    a_mode_follows: assert property (
        s_pre |=> ##[0:3] cmd == `SDPC_CMD_MODE_SET && memPins.addr == MODE_VALUE) else $error("no mode set");
    a_mode_gap: assert property (
        cmd == `SDPC_CMD_MODE_SET |=> !busy) else $error("command too soon after mode set");
    a_two_refresh: assert property (
        $rose(initDone) |-> refCnt >= 2'h2) else $error("too few init refreshes");
    a_entry_cmd: assert property (
        !memPins.clockGate && cmd[3:1] == 3'b000 |-> cmd[0] ##[0:1] inSelfRefresh) else $error("bad entry");
    a_sr_hold: assert property (
        entry |=> (!memPins.clockGate)[*2]) else $error("self refresh left too early");
    a_clk_stable: assert property (
        s_exit |-> $past(sysClkRun) && $past(sysClkRun, 4)) else $error("gate raised on unstable clock");
    a_exit_quiet: assert property (
        s_exit |-> (memPins.cmd.chipSelectN && memPins.clockGate)[*3]) else $error("exit not quiet");
    a_suspend_lag: assert property (
        $fell(memPins.clockGate) && cmd == `SDPC_CMD_NOP |=> suspended) else $error("suspend lag wrong");
    a_resume_lag: assert property (
        $rose(memPins.clockGate) && !inSelfRefresh && suspended |=> !suspended) else $error("resume lag wrong");
    a_no_access: assert property (
        !initDone |-> !(cmd inside {4'h3, 4'h4, 4'h5})) else $error("access before init");
endmodule // sdpc_ctrl_chk
bind sdpc_ctrl sdpc_ctrl_chk #(.PAUSE_CYC(PAUSE_CYC), .MODE_VALUE(MODE_VALUE)) u_sdpc_ctrl_chk (
    .sys_clk(sys_clk), .reset(reset), .clkEn(clkEn), .memPins(memPins), .sysClkRun(sysClkRun),
    .initDone(initDone), .inSelfRefresh(inSelfRefresh), .suspended(suspended));

// ### tb/sdpc_mem_model.sv
// Behavioural SDRAM seen at its command pins.
// Assumes pins are sampled on rising sys_clk while memClkRun is high.
`timescale 1ns/1ps
module sdpc_mem_model (
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire logic                 memClkRun,
    input  wire sdpc_pkg::sdpc_pins_s pins,
    output logic                      modeSet,
    output logic                      selfRefresh,
    output logic                      frozen,
    output logic                      protoErr,
    output logic [11:0]               refreshCnt
);
    import sdpc_pkg::*;
    logic precharged;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            precharged <= 1'b0;
            modeSet <= 1'b0;
            selfRefresh <= 1'b0;
            frozen <= 1'b0;
            protoErr <= 1'b0;
            refreshCnt <= '0;
        end else begin
            frozen <= !pins.clockGate && !selfRefresh;
            if (selfRefresh) begin
                if (pins.clockGate)
                    selfRefresh <= 1'b0;
            end else if (!memClkRun)
                protoErr <= 1'b1;
            else if (!pins.clockGate && pins.cmd == 4'h1)
                selfRefresh <= 1'b1;
            else if (!frozen) begin
                case (pins.cmd)
                    4'h2: precharged <= pins.addr[10];
                    4'h0: modeSet <= precharged;
                    4'h1: refreshCnt <= refreshCnt + 12'h1;
                    4'h7, 4'hf: ;
                    default: protoErr <= 1'b1;
                endcase
            end
        end
    end
endmodule // sdpc_mem_model

// ### tb/testbench.sv
// Self-checking bench for the SDRAM init and self-refresh controller.
// Assumes the design, the checker and the memory model are compiled first.
`timescale 1ns/1ps
`include "sdpc_params.svh"
module testbench;
    import sdpc_pkg::*;
    localparam int unsigned PAUSE = 20;
    localparam int unsigned BURST = 3;
    logic        sys_clk, reset, clkEn, burstRefreshMode, selfRefreshReq, suspendReq;
    sdpc_pins_s  memPins;
    logic        sysClkRun, initDone, inSelfRefresh, suspended, modeSet, selfRefresh, frozen, protoErr;
    logic [11:0] refreshCnt, base;
    int          error_cnt = 0, n_checks = 0, cycles = 0;
    sdpc_ctrl #(.PAUSE_CYC(PAUSE), .BURST_COUNT(BURST)) u_sdpc_ctrl (.sys_clk(sys_clk), .reset(reset),
        .clkEn(clkEn), .burstRefreshMode(burstRefreshMode), .selfRefreshReq(selfRefreshReq),
        .suspendReq(suspendReq), .memPins(memPins), .sysClkRun(sysClkRun), .initDone(initDone),
        .inSelfRefresh(inSelfRefresh), .suspended(suspended));
    sdpc_mem_model u_sdpc_mem_model (.sys_clk(sys_clk), .reset(reset), .memClkRun(sysClkRun), .pins(memPins),
        .modeSet(modeSet), .selfRefresh(selfRefresh), .frozen(frozen), .protoErr(protoErr), .refreshCnt(refreshCnt));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wait_for(ref logic sig, input logic val, input int lim);
        int n;
        n = 0;
        while (sig !== val && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
    endtask
    task automatic t_power_up;
        int n;
        n = 0;
        check("reset pins", {memPins.cmd, memPins.clockGate, memPins.byteMask}, 9'h0ff);
        check("clock in reset", sysClkRun, 1'b1);
        reset = 1'b0;
        while (memPins.cmd === `SDPC_CMD_NOP && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        check("pause length", 16'(n >= PAUSE), 16'h1);
        check("first command", {memPins.cmd, memPins.addr[`SDPC_A10_BIT]}, 5'h05);
        wait_for(initDone, 1'b1, 200);
        check("mode loaded", modeSet, 1'b1);
        check("init refreshes", refreshCnt, 12'h2);
    endtask
    task automatic t_self_refresh;
        // A frozen clock enable must hold off the request, so the missing entry while clkEn is low proves clkEn reaches the state.
        clkEn = 1'b0;
        selfRefreshReq = 1'b1;
        repeat (4) @(negedge sys_clk);
        check("frozen", inSelfRefresh, 1'b0);
        clkEn = 1'b1;
        wait_for(inSelfRefresh, 1'b1, 10);
        // The memory takes the entry command one edge after the pins show it.
        @(negedge sys_clk);
        check("entered", selfRefresh, 1'b1);
        repeat (6) @(negedge sys_clk);
        check("clock stopped", {sysClkRun, selfRefresh}, 2'b01);
        selfRefreshReq = 1'b0;
        wait_for(inSelfRefresh, 1'b0, 30);
        check("exited", {selfRefresh, memPins.clockGate, protoErr}, 3'b010);
    endtask
    task automatic t_burst;
        burstRefreshMode = 1'b1;
        base = refreshCnt;
        selfRefreshReq = 1'b1;
        wait_for(inSelfRefresh, 1'b1, 60);
        check("burst before entry", refreshCnt - base, 16'(BURST));
        selfRefreshReq = 1'b0;
        wait_for(inSelfRefresh, 1'b0, 60);
        repeat (20) @(negedge sys_clk);
        check("burst after exit", refreshCnt - base, 16'(2 * BURST));
        burstRefreshMode = 1'b0;
    endtask
    task automatic t_suspend;
        suspendReq = 1'b1;
        @(negedge sys_clk);
        check("gate low", memPins.clockGate, 1'b0);
        @(negedge sys_clk);
        check("suspended", {suspended, frozen}, 2'b11);
        suspendReq = 1'b0;
        repeat (2) @(negedge sys_clk);
        check("resumed", {memPins.clockGate, suspended, frozen, protoErr}, 4'b1000);
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    initial begin
        reset = 1'b1;
        clkEn = 1'b1;
        burstRefreshMode = 1'b0;
        selfRefreshReq = 1'b0;
        suspendReq = 1'b0;
        repeat (3) @(negedge sys_clk);
        cycles = 0;
        t_power_up();
        t_self_refresh();
        t_suspend();
        t_burst();
        report_and_stop();
    end
endmodule // testbench
